// ===== verification/board_load.sv
// Board-side load model for port pins two to four
`timescale 1ns/1ps
module board_load (
	// Clock
	input wire logic clk,
	// Pin drive from the device
	input wire logic [2:0] portPinOut,
	input wire logic [2:0] portPinOutEn,
	// Board-side source
	input wire logic boardEn,
	input wire logic [2:0] boardVal,
	// Resolved pin level
	output logic [2:0] portPinIn
);
	// ==================================================================
	// Floating level
	logic [2:0] floatPat_r = 3'h5;

	// Undriven pins wander every cycle rather than hold a stale level
	always @(posedge clk) begin
		floatPat_r <= ~floatPat_r;
	end

	// Device drive wins, else board source, else floating pattern
	assign portPinIn = (portPinOutEn & portPinOut) |
		(~portPinOutEn & (boardEn ? boardVal : floatPat_r));
endmodule : board_load

// ===== verification/tb_port_pin_mux.sv
// Self-checking bench for the port pin two-to-four multiplexer
`timescale 1ns/1ps
module tb_port_pin_mux;
	// ==================================================================
	// Stimulus and observation
	logic clk = 0, reset_n = 0, eightyPinPackage = 1, boardEn = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, seed = 30;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic extBusActive = 0, extBusDrive = 0, parallelPortActive = 0;
	logic parallelPortByteEnable = 0, parallelPortAddrBitThirteen = 0;
	logic parallelPortAddrBitTwelve = 0, pwmTwoChannelBEn = 0, pwmTwoChannelB = 0;
	logic pwmThreeChannelCEn = 0, pwmThreeChannelC = 0, pwmThreeChannelBEn = 0;
	logic pwmThreeChannelB = 0, pwmShutdown = 0, referenceClockOut = 0;
	logic [2:0] extBusAddrData = 0, boardVal = 0, extBusReadData, portPinIn;
	logic [2:0] portPinOut, portPinOutEn, latchVal, dirVal;
	logic [4:0] cfgVal;
	int bad_count = 0, n_checks = 0;

	// Clock
	always #12.5 clk = ~clk;

	port_pin_mux dut (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .eightyPinPackage,
		.extBusActive, .extBusDrive, .extBusAddrData, .extBusReadData,
		.parallelPortActive, .parallelPortByteEnable, .parallelPortAddrBitThirteen,
		.parallelPortAddrBitTwelve, .pwmTwoChannelBEn, .pwmTwoChannelB,
		.pwmThreeChannelCEn, .pwmThreeChannelC, .pwmThreeChannelBEn, .pwmThreeChannelB,
		.pwmShutdown, .referenceClockOut, .portPinIn, .portPinOut, .portPinOutEn);
	board_load load (.clk, .portPinOut, .portPinOutEn, .boardEn, .boardVal, .portPinIn);

	// ==================================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Expected {enable, data} of the three pins, by fixed priority
	function automatic logic [5:0] expPins();
		logic [2:0] en, o, pe, pd, par;
		logic ext, rt;
		ext = eightyPinPackage & cfgVal[0] & extBusActive;
		rt = cfgVal[1] & eightyPinPackage;
		pe = {pwmThreeChannelBEn & rt, pwmThreeChannelCEn & rt, pwmTwoChannelBEn} & ~dirVal;
		pd = {pwmThreeChannelB, pwmThreeChannelC, pwmTwoChannelB};
		par = {parallelPortAddrBitTwelve, parallelPortAddrBitThirteen, parallelPortByteEnable};
		for (int i = 0; i < 3; i++) begin
			if (ext) begin
				en[i] = extBusDrive;
				o[i] = extBusAddrData[i];
			end else if (pe[i]) begin
				en[i] = !(pwmShutdown & cfgVal[4]);
				o[i] = pd[i];
			end else if (i == 1 && cfgVal[3]) begin
				en[i] = 1'b1;
				o[i] = referenceClockOut;
			end else if (parallelPortActive & cfgVal[2]) begin
				en[i] = 1'b1;
				o[i] = par[i];
			end else begin
				en[i] = !dirVal[i];
				o[i] = latchVal[i];
			end
		end
		return {en, o & en};
	endfunction : expPins

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic hang(input string nm);
		chk(nm, 32'h0, 32'h1);
		results();
	endtask : hang

	// Bus write, entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
		int n;
		logic pa, pw, ta, tw;
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		n = 0;
		while ((pa || pw) && n < 40) begin
			@(negedge clk);
			ta = pa && s_axi_awready === 1'b1;
			tw = pw && s_axi_wready === 1'b1;
			@(posedge clk);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				s_axi_wvalid <= 1'b0;
				pw = 1'b0;
			end
			n++;
		end
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		rs = s_axi_bresp;
		// Ready stays up between transfers; the response is taken at this edge
		@(posedge clk);
		if (n >= 40 || pa || pw) hang("writeResponse");
	endtask : wr

	// Bus read, entered just after a rising edge
	task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
		int n;
		logic t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			t = s_axi_arready;
			@(posedge clk);
			n++;
		end while (t !== 1'b1 && n < 40);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 80);
		dat = s_axi_rdata;
		rs = s_axi_rresp;
		// Ready stays up between transfers; the data is taken at this edge
		@(posedge clk);
		if (n >= 80) hang("readResponse");
	endtask : rd

	// Pins settle one clock after their causes
	task automatic pinCheck();
		logic [5:0] e;
		repeat (2) @(posedge clk);
		@(negedge clk);
		e = expPins();
		chk("pinEnable", portPinOutEn, e[5:3]);
		chk("pinData", portPinOut & e[5:3], e[2:0]);
		@(posedge clk);
	endtask : pinCheck

	// ==================================================================
	// Main sequence: both package straps
	initial begin
		for (int p = 1; p >= 0; p--) begin
			reset_n <= 1'b0;
			eightyPinPackage <= p[0];
			boardEn <= 1'b0;
			repeat (2) @(posedge clk);
			reset_n <= 1'b1;
			latchVal = pin_mux_pkg::LATCH_RESET;
			dirVal = pin_mux_pkg::DIR_RESET;
			cfgVal = pin_mux_pkg::CFG_RESET;
			@(posedge clk);
			rd(pin_mux_pkg::OFS_LATCH, d, r);
			chk("latchReset", d, 32'h0);
			rd(pin_mux_pkg::OFS_DIR, d, r);
			chk("dirReset", d, {27'h0, pin_mux_pkg::DIR_RESET, 2'h0});
			rd(pin_mux_pkg::OFS_CFG, d, r);
			chk("cfgReset", d, {27'h0, pin_mux_pkg::CFG_RESET});
			rd(pin_mux_pkg::OFS_STATUS, d, r);
			chk("strapBit", d[12], p[0]);
			wr(8'h14, 32'h1F, r);
			chk("unmappedWrite", r, pin_mux_pkg::RESP_SLVERR);
			rd(8'h14, d, r);
			chk("unmappedRead", d, 32'h0);
			chk("unmappedResp", r, pin_mux_pkg::RESP_SLVERR);
			pinCheck();
			$display("test registers done, strap %0d", p);
			// Random register settings and function requests
			for (int k = 0; k < 150; k++) begin
				d = rnd();
				latchVal = d[2:0];
				dirVal = d[5:3];
				cfgVal = d[10:6];
				wr(pin_mux_pkg::OFS_LATCH, {27'h0, latchVal, 2'h0}, r);
				wr(pin_mux_pkg::OFS_DIR, {27'h0, dirVal, 2'h0}, r);
				wr(pin_mux_pkg::OFS_CFG, {27'h0, cfgVal}, r);
				chk("cfgResp", r, pin_mux_pkg::RESP_OKAY);
				d = rnd();
				{extBusActive, extBusDrive, parallelPortActive, parallelPortByteEnable,
					parallelPortAddrBitThirteen, parallelPortAddrBitTwelve, pwmTwoChannelBEn,
					pwmTwoChannelB, pwmThreeChannelCEn, pwmThreeChannelC, pwmThreeChannelBEn,
					pwmThreeChannelB, pwmShutdown, referenceClockOut} <= d[13:0];
				extBusAddrData <= d[16:14];
				boardEn <= d[17];
				boardVal <= d[20:18];
				pinCheck();
			end
			$display("test priority done, strap %0d", p);
			// Pins as inputs, external bus reading
			latchVal = 3'h0;
			dirVal = 3'h7;
			cfgVal = 5'h01;
			wr(pin_mux_pkg::OFS_DIR, 32'h1C, r);
			wr(pin_mux_pkg::OFS_CFG, 32'h01, r);
			for (int k = 0; k < 4; k++) begin
				d = rnd();
				extBusActive <= 1'b1;
				extBusDrive <= 1'b0;
				boardEn <= 1'b1;
				boardVal <= d[2:0];
				repeat (8) @(posedge clk);
				// Look between edges, where the registered outputs are settled
				@(negedge clk);
				chk("inputEnable", portPinOutEn, 3'h0);
				chk("extReadData", extBusReadData, d[2:0]);
				@(posedge clk);
				rd(pin_mux_pkg::OFS_PORT, d, r);
				chk("portInput", d[4:2], boardVal);
			end
			$display("test inputs done, strap %0d", p);
		end
		results();
	end
endmodule : tb_port_pin_mux

// ===== verilog/pin_mux_pkg.sv
// Constants and types shared by the port pin two-to-four multiplexer
package pin_mux_pkg;

	// ==================================================================
	// Pin geometry
	localparam int PIN_COUNT = 3;
	localparam int PIN_LSB = 2;

	// ==================================================================
	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_LATCH = 8'h00;
	localparam logic [7:0] OFS_DIR = 8'h04;
	localparam logic [7:0] OFS_PORT = 8'h08;
	localparam logic [7:0] OFS_CFG = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// ==================================================================
	// Configuration register field positions
	localparam int CFG_EXT_BUS = 0;
	localparam int CFG_PWM_ROUTE = 1;
	localparam int CFG_PAR_ROUTE = 2;
	localparam int CFG_REFCLK = 3;
	localparam int CFG_PWM_TRI = 4;
	localparam int CFG_WIDTH = 5;

	// ==================================================================
	// Status register field positions
	localparam int STATUS_OWNER_W = 3;
	localparam int STATUS_PKG_BIT = 12;

	// ==================================================================
	// Reset values
	localparam logic [2:0] LATCH_RESET = 3'h0;
	localparam logic [2:0] DIR_RESET = 3'h7;
	localparam logic [4:0] CFG_RESET = 5'h04;

	// ==================================================================
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==================================================================
	// Function currently owning a pin
	typedef enum logic [2:0] {
		OWN_LATCH = 3'h0,
		OWN_INPUT = 3'h1,
		OWN_PARALLEL = 3'h2,
		OWN_REFCLK = 3'h3,
		OWN_PWM = 3'h4,
		OWN_EXT_BUS = 3'h5,
		OWN_OFF = 3'h6
	} owner_t;

endpackage : pin_mux_pkg

// ===== verilog/pin_owner_mux.sv
// Priority selection of source and drive for one shared port pin
`timescale 1ns/1ps
module pin_owner_mux (
	// External memory bus request
	input wire logic extReq,
	input wire logic extDrive,
	input wire logic extData,
	// PWM channel request
	input wire logic pwmReq,
	input wire logic pwmTri,
	input wire logic pwmData,
	// Reference clock request
	input wire logic refReq,
	input wire logic refData,
	// Parallel master port request
	input wire logic parReq,
	input wire logic parData,
	// Port latch and direction
	input wire logic dirBit,
	input wire logic latchBit,
	// Selected result
	output pin_mux_pkg::owner_t owner,
	output logic pinData,
	output logic pinDrive
);

	// ==================================================================
	// Owner priority chain
	assign owner = extReq ? pin_mux_pkg::OWN_EXT_BUS :
		pwmReq ? (pwmTri ? pin_mux_pkg::OWN_OFF : pin_mux_pkg::OWN_PWM) :
		refReq ? pin_mux_pkg::OWN_REFCLK :
		parReq ? pin_mux_pkg::OWN_PARALLEL :
		dirBit ? pin_mux_pkg::OWN_INPUT : pin_mux_pkg::OWN_LATCH;

	// Data and drive follow the owner; direction bit only for the port
	assign pinData = extReq ? extData : pwmReq ? pwmData : refReq ? refData :
		parReq ? parData : latchBit;
	assign pinDrive = extReq ? extDrive : pwmReq ? !pwmTri : (refReq | parReq | !dirBit);

endmodule : pin_owner_mux

// ===== verilog/port_pin_mux.sv
// Pin multiplexer for port pins two to four with an AXI4-Lite register file
// Operation
// [RULE_01] External bus owns pin above every function
// [RULE_02] External bus only on eighty-pin package
// [RULE_03] Pins carry external address/data bits 10-12
// [RULE_04] Enabled PWM output overrides latch and parallel; the code does so only while the pin's direction bit is clear
// [RULE_05] PWM shutdown may tri-state PWM pins
// [RULE_06] Module three B/C routed by config bit
// [RULE_07] Parallel strobes only when routing bit set
// [RULE_08] Pin two outputs parallel byte enable
// [RULE_09] Pins three, four output parallel addr 13/12
// [RULE_10] Owning function, not direction bit, sets direction
// [RULE_11] Otherwise direction bit picks latch or input
// [RULE_12] Enabled reference clock drives pin three
`timescale 1ns/1ps
module port_pin_mux (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Package strap, caught while reset is held
	input wire logic eightyPinPackage,
	// External memory bus, index 0..2 is ext_bus_bit_ten..twelve
	input wire logic extBusActive,
	input wire logic extBusDrive,
	input wire logic [2:0] extBusAddrData,
	output logic [2:0] extBusReadData,
	// Parallel master port
	input wire logic parallelPortActive,
	input wire logic parallelPortByteEnable,
	input wire logic parallelPortAddrBitThirteen,
	input wire logic parallelPortAddrBitTwelve,
	// PWM channels and shutdown
	input wire logic pwmTwoChannelBEn,
	input wire logic pwmTwoChannelB,
	input wire logic pwmThreeChannelCEn,
	input wire logic pwmThreeChannelC,
	input wire logic pwmThreeChannelBEn,
	input wire logic pwmThreeChannelB,
	input wire logic pwmShutdown,
	// Reference clock
	input wire logic referenceClockOut,
	// Pins, index 0..2 is port_pin_two..four
	input wire logic [2:0] portPinIn,
	output logic [2:0] portPinOut,
	output logic [2:0] portPinOutEn
);

	// ==================================================================
	// Registers and wires
	logic [2:0] latch_r;
	logic [2:0] dir_r;
	logic [4:0] cfg_r;
	logic eightyPin_r;
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [2:0] sync3_r;
	logic [2:0] portInputValue_r;
	logic [2:0] pinOut_r;
	logic [2:0] pinOutEn_r;
	pin_mux_pkg::owner_t ownerR [3];
	pin_mux_pkg::owner_t owner [3];
	logic [2:0] pinData;
	logic [2:0] pinDrive;
	logic [2:0] extReq;
	logic [2:0] pwmReq;
	logic [2:0] pwmData;
	logic [2:0] refReq;
	logic [2:0] parReq;
	logic [2:0] parData;
	logic pwmTri;
	logic pwmRouteOk;
	logic awHeld_r;
	logic wHeld_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic bValid_r;
	logic [1:0] bResp_r;
	logic rValid_r;
	logic [31:0] rData_r;
	logic [1:0] rResp_r;
	logic doWrite;
	logic doRead;
	logic [31:0] rdValue;
	logic rdHit;
	logic wrHit;

	// ==================================================================
	// Byte-lane merge of a low-byte field
	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		lane0 = strb[0] ? data[7:0] : old;
	endfunction : lane0

	// Address decode of a mapped register
	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr == pin_mux_pkg::OFS_LATCH) || (addr == pin_mux_pkg::OFS_DIR) ||
			(addr == pin_mux_pkg::OFS_PORT) || (addr == pin_mux_pkg::OFS_CFG) ||
			(addr == pin_mux_pkg::OFS_STATUS);
	endfunction : mapped

	// ==================================================================
	// Per-pin requests
	assign pwmTri = pwmShutdown & cfg_r[pin_mux_pkg::CFG_PWM_TRI]; // [RULE_05]
	assign pwmRouteOk = cfg_r[pin_mux_pkg::CFG_PWM_ROUTE] & eightyPin_r; // [RULE_06]
	assign extReq = {3{eightyPin_r & cfg_r[pin_mux_pkg::CFG_EXT_BUS] & extBusActive}}; // [RULE_02]
	assign pwmReq = {pwmThreeChannelBEn & pwmRouteOk, pwmThreeChannelCEn & pwmRouteOk,
		pwmTwoChannelBEn} & ~dir_r; // [RULE_06]
	assign pwmData = {pwmThreeChannelB, pwmThreeChannelC, pwmTwoChannelB};
	assign refReq = {1'b0, cfg_r[pin_mux_pkg::CFG_REFCLK], 1'b0}; // [RULE_12]
	assign parReq = {3{parallelPortActive & cfg_r[pin_mux_pkg::CFG_PAR_ROUTE]}}; // [RULE_07]
	assign parData = {parallelPortAddrBitTwelve, parallelPortAddrBitThirteen,
		parallelPortByteEnable}; // [RULE_08] [RULE_09]

	// Priority selection per pin
	for (genvar i = 0; i < pin_mux_pkg::PIN_COUNT; i++) begin : gPin
		pin_owner_mux uMux (
			.extReq(extReq[i]), // [RULE_01]
			.extDrive(extBusDrive),
			.extData(extBusAddrData[i]), // [RULE_03]
			.pwmReq(pwmReq[i]), // [RULE_04]
			.pwmTri(pwmTri),
			.pwmData(pwmData[i]),
			.refReq(refReq[i]),
			.refData(referenceClockOut),
			.parReq(parReq[i]),
			.parData(parData[i]),
			.dirBit(dir_r[i]), // [RULE_10] [RULE_11]
			.latchBit(latch_r[i]),
			.owner(owner[i]),
			.pinData(pinData[i]),
			.pinDrive(pinDrive[i])
		);
	end

	// ==================================================================
	// Pin output registers and owner record
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pinOut_r <= 3'h0;
			pinOutEn_r <= 3'h0;
			ownerR <= '{default: pin_mux_pkg::OWN_INPUT};
		end else begin
			pinOut_r <= pinData;
			pinOutEn_r <= pinDrive;
			ownerR <= owner;
		end
	end

	assign portPinOut = pinOut_r;
	assign portPinOutEn = pinOutEn_r;

	// Package strap sampled while reset is low, held after release
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			eightyPin_r <= eightyPinPackage;
		end
	end

	// Pin input synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			sync3_r <= 3'h0;
			portInputValue_r <= 3'h0;
		end else begin
			sync1_r <= portPinIn;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			for (int i = 0; i < pin_mux_pkg::PIN_COUNT; i++) begin
				if (sync2_r[i] == sync3_r[i]) begin
					portInputValue_r[i] <= sync3_r[i];
				end
			end
		end
	end

	assign extBusReadData = portInputValue_r; // [RULE_03]

	// ==================================================================
	// AXI4-Lite write channel
	assign s_axi_awready = !awHeld_r && !bValid_r;
	assign s_axi_wready = !wHeld_r && !bValid_r;
	assign doWrite = awHeld_r && wHeld_r && !bValid_r;
	assign wrHit = mapped(awAddr_r);
	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp = bResp_r;

	// Address and data capture in either order, response after both
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			bValid_r <= 1'b0;
			bResp_r <= pin_mux_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				bValid_r <= 1'b1;
				bResp_r <= wrHit ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR;
			end else if (bValid_r && s_axi_bready) begin
				bValid_r <= 1'b0;
			end
		end
	end

	// Writable registers; port, status read only
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			latch_r <= pin_mux_pkg::LATCH_RESET;
			dir_r <= pin_mux_pkg::DIR_RESET;
			cfg_r <= pin_mux_pkg::CFG_RESET;
		end else if (doWrite) begin
			if (awAddr_r == pin_mux_pkg::OFS_LATCH) begin
				latch_r <= 3'(lane0({3'h0, latch_r, 2'h0}, wData_r, wStrb_r) >> 2);
			end
			if (awAddr_r == pin_mux_pkg::OFS_DIR) begin
				dir_r <= 3'(lane0({3'h0, dir_r, 2'h0}, wData_r, wStrb_r) >> 2);
			end
			if (awAddr_r == pin_mux_pkg::OFS_CFG) begin
				cfg_r <= 5'(lane0({3'h0, cfg_r}, wData_r, wStrb_r));
			end
		end
	end

	// ==================================================================
	// AXI4-Lite read channel
	assign s_axi_arready = !rValid_r;
	assign doRead = s_axi_arvalid && s_axi_arready;
	assign rdHit = mapped(s_axi_araddr);
	assign rdValue =
		(s_axi_araddr == pin_mux_pkg::OFS_LATCH) ? {27'h0, latch_r, 2'h0} :
		(s_axi_araddr == pin_mux_pkg::OFS_DIR) ? {27'h0, dir_r, 2'h0} :
		(s_axi_araddr == pin_mux_pkg::OFS_PORT) ? {27'h0, portInputValue_r, 2'h0} : // [RULE_11]
		(s_axi_araddr == pin_mux_pkg::OFS_CFG) ? {27'h0, cfg_r} :
		(s_axi_araddr == pin_mux_pkg::OFS_STATUS) ?
		{19'h0, eightyPin_r, 3'h0, ownerR[2], ownerR[1], ownerR[0]} : 32'h0000_0000;
	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata = rData_r;
	assign s_axi_rresp = rResp_r;

	// Read data registered at the edge that takes the address, valid in the cycle after
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rValid_r <= 1'b0;
			rData_r <= 32'h0000_0000;
			rResp_r <= pin_mux_pkg::RESP_OKAY;
		end else if (doRead) begin
			rValid_r <= 1'b1;
			rData_r <= rdValue;
			rResp_r <= rdHit ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR;
		end else if (rValid_r && s_axi_rready) begin
			rValid_r <= 1'b0;
		end
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence extClaim(int i);
		extReq[i] && extBusDrive;
	endsequence

	ext_prio_a: assert property (extClaim(0) |=> portPinOutEn[0] && // [RULE_01]
		portPinOut[0] == $past(extBusAddrData[0]))
		else $error("external bus did not own pin two");
	small_pkg_a: assert property (!eightyPin_r |=> ownerR[0] != pin_mux_pkg::OWN_EXT_BUS && // [RULE_02]
		ownerR[1] != pin_mux_pkg::OWN_EXT_BUS && ownerR[2] != pin_mux_pkg::OWN_EXT_BUS)
		else $error("external bus took a pin on small package");
	ext_read_a: assert property (extReq[2] && !extBusDrive |=> !portPinOutEn[2] ##3 // [RULE_03]
		extBusReadData[2] == $past(portPinIn[2], 4) || $past(sync2_r[2]) != $past(sync3_r[2]))
		else $error("external bus read path wrong on pin four");
	pwm_over_a: assert property (pwmReq[0] && !extReq[0] && !pwmTri |=> // [RULE_04]
		portPinOutEn[0] && portPinOut[0] == $past(pwmTwoChannelB))
		else $error("PWM did not override pin two");
	pwm_shut_a: assert property (pwmReq[1] && !extReq[1] && pwmShutdown && // [RULE_05]
		cfg_r[pin_mux_pkg::CFG_PWM_TRI] |=> !portPinOutEn[1])
		else $error("PWM shutdown did not tri-state pin three");
	pwm_route_a: assert property (!pwmRouteOk |=> ownerR[2] != pin_mux_pkg::OWN_PWM && // [RULE_06]
		ownerR[1] != pin_mux_pkg::OWN_PWM)
		else $error("module three routed without routing bit");
	par_gate_a: assert property (!cfg_r[pin_mux_pkg::CFG_PAR_ROUTE] |=> // [RULE_07]
		ownerR[0] != pin_mux_pkg::OWN_PARALLEL && ownerR[2] != pin_mux_pkg::OWN_PARALLEL)
		else $error("parallel port appeared without routing bit");
	byte_en_a: assert property (owner[0] == pin_mux_pkg::OWN_PARALLEL |=> portPinOutEn[0] && // [RULE_08]
		portPinOut[0] == $past(parallelPortByteEnable))
		else $error("pin two byte enable wrong");
	par_addr_a: assert property (owner[1] == pin_mux_pkg::OWN_PARALLEL && // [RULE_09]
		owner[2] == pin_mux_pkg::OWN_PARALLEL |=> portPinOut[1] == $past(parallelPortAddrBitThirteen)
		&& portPinOut[2] == $past(parallelPortAddrBitTwelve))
		else $error("parallel address bits on wrong pins");
	dir_ignore_a: assert property ((owner[1] == pin_mux_pkg::OWN_REFCLK || // [RULE_10]
		owner[1] == pin_mux_pkg::OWN_PARALLEL) && dir_r[1] |=> portPinOutEn[1])
		else $error("direction bit overrode owning function");
	port_dir_a: assert property (owner[2] == pin_mux_pkg::OWN_LATCH |=> portPinOutEn[2] && // [RULE_11]
		portPinOut[2] == $past(latch_r[2]))
		else $error("latch not driven on pin four");
	port_in_a: assert property (owner[0] == pin_mux_pkg::OWN_INPUT |=> !portPinOutEn[0]) // [RULE_11]
		else $error("input pin two was driven");
	ref_out_a: assert property (cfg_r[pin_mux_pkg::CFG_REFCLK] && !extReq[1] && !pwmReq[1] |=> // [RULE_12]
		portPinOutEn[1] && portPinOut[1] == $past(referenceClockOut))
		else $error("reference clock missing on pin three");

endmodule : port_pin_mux
